// File: bcs_pkg.sv
// Purpose: Shared constants and types for the bus-cycle sequencer
// Assumes: One bus cycle per clock; opcode map is local to this core
// Notes:   Opcode = mode nibble in [7:4], operation nibble in [3:0]
package bcs_pkg;

  // Mode nibbles; bit 4 of the opcode selects direct over immediate
  localparam logic [3:0] MODE_IMM       = 4'h8;
  localparam logic [3:0] MODE_DIR       = 4'h9;
  localparam logic [3:0] MODE_IMM_WIDE  = 4'hC;
  localparam logic [3:0] MODE_DIR_WIDE  = 4'hD;

  // Operation nibbles in the 8/9 groups
  localparam logic [3:0] OP_SUBTRACT_ACC        = 4'h0;
  localparam logic [3:0] OP_COMPARE_ACCUMULATOR = 4'h1;
  localparam logic [3:0] OP_SUBTRACT_WITH_CARRY = 4'h2;
  localparam logic [3:0] OP_SUBTRACT_DOUBLE     = 4'h3;
  localparam logic [3:0] OP_AND_ACC             = 4'h4;
  localparam logic [3:0] OP_BIT_TEST            = 4'h5;
  localparam logic [3:0] OP_LOAD_ACCUMULATOR    = 4'h6;
  localparam logic [3:0] OP_STORE_ACCUMULATOR   = 4'h7;
  localparam logic [3:0] OP_EXCLUSIVE_OR_ACC    = 4'h8;
  localparam logic [3:0] OP_ADD_WITH_CARRY      = 4'h9;
  localparam logic [3:0] OP_INCLUSIVE_OR_ACC    = 4'hA;
  localparam logic [3:0] OP_ADD_ACC             = 4'hB;
  localparam logic [3:0] OP_COMPARE_INDEX       = 4'hC;
  localparam logic [3:0] OP_SUBROUTINE_CALL     = 4'hD;
  localparam logic [3:0] OP_LOAD_STACK_POINTER  = 4'hE;
  localparam logic [3:0] OP_STORE_STACK_POINTER = 4'hF;
  // Operation nibbles in the C/D groups
  localparam logic [3:0] OP_ADD_DOUBLE          = 4'h3;
  localparam logic [3:0] OP_LOAD_DOUBLE         = 4'hC;
  localparam logic [3:0] OP_STORE_DOUBLE        = 4'hD;
  localparam logic [3:0] OP_LOAD_INDEX          = 4'hE;
  localparam logic [3:0] OP_STORE_INDEX         = 4'hF;

  localparam logic [15:0] DUMMY_ADDR   = 16'hFFFF;
  localparam logic [15:0] START_ADDR   = 16'h0000;
  localparam logic [15:0] INT_BASE     = 16'h0080;
  localparam int          INT_DEPTH    = 128;
  localparam logic [15:0] LEN_SHORT    = 16'h0002;
  localparam logic [15:0] LEN_WIDE_IMM = 16'h0003;
  localparam logic [15:0] LEN_UNKNOWN  = 16'h0001;

  typedef enum logic [3:0] {
    CL_NONE, CL_ACC_IMM, CL_ACC_DIR, CL_STA, CL_LD16_IMM, CL_LD16_DIR,
    CL_ST16, CL_AR16_IMM, CL_AR16_DIR, CL_JSR
  } bcs_cls_e;

  typedef enum logic [1:0] { SRC_D, SRC_X, SRC_S } bcs_src_e;

  typedef enum logic [2:0] { ST_OPC, ST_C2, ST_C3, ST_C4, ST_C5 } bcs_st_e;

  typedef struct packed {
    bcs_cls_e cls;
    bcs_src_e src;
  } bcs_dec_s;

  typedef struct packed {
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  dout;
    logic        doe;
  } bcs_bus_s;

endpackage : bcs_pkg

// File: bcs_seq.sv
// Purpose: Bus-cycle sequencer, immediate and direct forms
// Assumes: One processor bus cycle per i_clk; core registers are inputs
// Notes:   Internal RAM lives here so internal reads can stay off the bus
// Operation
// [RULE1] Each cycle drives an address with rw high to read, low to write; direct accumulator store is three cycles ending in an accumulator write.
// [RULE2] All 8-bit accumulator ops: immediate is opcode then operand at pc+1, direct is opcode, address byte, operand read; store acc writes or is a no-op.
// [RULE3] Sixteen-bit values move high byte first at the lower address, low byte next; the call return push writes the low byte first.
// [RULE4] Internal reads stay off the external data bus except in mode zero.
// [RULE5] Immediate 16-bit loads read opcode, high byte at pc+1, low byte at pc+2.
// [RULE6] Direct 16-bit loads read opcode, address byte, high byte there, low byte at the next address.
// [RULE7] Direct 16-bit stores read opcode and address, then write high then low byte.
// [RULE8] Compare index, subtract and add double end with a dummy read of FFFF.
// [RULE9] Direct subroutine call reads opcode, pc+1, then the first opcode at the target.
// [RULE10] Call cycles four and five write return low at the stack pointer, then high at plus one.
// [RULE11] The next opcode fetch follows the last cycle with no idle cycle.
`timescale 1ns/10ps
module bcs_seq #(
  parameter logic [15:0] P_START = bcs_pkg::START_ADDR,
  parameter logic [15:0] P_BASE  = bcs_pkg::INT_BASE,
  parameter int          P_DEPTH = bcs_pkg::INT_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_din,
  input  wire logic        i_mode0,
  input  wire logic [7:0]  i_acc,
  input  wire logic [15:0] i_dreg,
  input  wire logic [15:0] i_xreg,
  input  wire logic [15:0] i_sreg,
  output logic      [15:0] o_addr,
  output logic             o_rw,
  output logic      [7:0]  o_dout,
  output logic             o_doe,
  output logic             o_fetch,
  output logic      [15:0] o_opnd,
  output logic             o_opnd_vld
);
  localparam int AW = $clog2(P_DEPTH);

  bcs_pkg::bcs_bus_s bus_q, bus_d;
  bcs_pkg::bcs_st_e  st_q, st_d;
  bcs_pkg::bcs_cls_e cls_q, cls_d;
  bcs_pkg::bcs_src_e src_q, src_d;
  bcs_pkg::bcs_dec_s dec;
  logic [15:0]       pc_q, pc_d, nxt_q, nxt_d, opnd_q, opnd_d, sv;
  logic [7:0]        ea_q, ea_d, rd, wdat;
  logic              vld_q, vld_d, fin, wr, cap;
  logic              fetch_q, fetch_d;
  logic [7:0]        ram_q [P_DEPTH];

  function automatic logic is_int(input logic [15:0] a);
    return (a >= P_BASE) && ({1'b0, a} < ({1'b0, P_BASE} + 17'(P_DEPTH)));
  endfunction : is_int

  function automatic logic [AW-1:0] idx(input logic [15:0] a);
    logic [15:0] off;
    off = a - P_BASE;
    return off[AW-1:0];
  endfunction : idx

  function automatic bcs_pkg::bcs_dec_s decode(input logic [7:0] op);
    bcs_pkg::bcs_dec_s r;
    logic              dir;
    r.cls = bcs_pkg::CL_NONE;
    r.src = bcs_pkg::SRC_D;
    dir   = op[4];
    if (op[7:4] == bcs_pkg::MODE_IMM || op[7:4] == bcs_pkg::MODE_DIR) begin
      unique case (op[3:0])
        bcs_pkg::OP_STORE_ACCUMULATOR: r.cls = dir ? bcs_pkg::CL_STA : bcs_pkg::CL_NONE;
        bcs_pkg::OP_SUBTRACT_DOUBLE,
        bcs_pkg::OP_COMPARE_INDEX:
          r.cls = dir ? bcs_pkg::CL_AR16_DIR : bcs_pkg::CL_AR16_IMM;
        bcs_pkg::OP_SUBROUTINE_CALL: r.cls = dir ? bcs_pkg::CL_JSR : bcs_pkg::CL_NONE;
        bcs_pkg::OP_LOAD_STACK_POINTER: begin
          r.cls = dir ? bcs_pkg::CL_LD16_DIR : bcs_pkg::CL_LD16_IMM;
          r.src = bcs_pkg::SRC_S;
        end
        bcs_pkg::OP_STORE_STACK_POINTER: begin
          r.cls = dir ? bcs_pkg::CL_ST16 : bcs_pkg::CL_NONE;
          r.src = bcs_pkg::SRC_S;
        end
        default: r.cls = dir ? bcs_pkg::CL_ACC_DIR : bcs_pkg::CL_ACC_IMM; // [RULE2]
      endcase
    end else if (op[7:4] == bcs_pkg::MODE_IMM_WIDE || op[7:4] == bcs_pkg::MODE_DIR_WIDE) begin
      unique case (op[3:0])
        bcs_pkg::OP_ADD_DOUBLE: r.cls = dir ? bcs_pkg::CL_AR16_DIR : bcs_pkg::CL_AR16_IMM;
        bcs_pkg::OP_LOAD_DOUBLE,
        bcs_pkg::OP_LOAD_INDEX: begin
          r.cls = dir ? bcs_pkg::CL_LD16_DIR : bcs_pkg::CL_LD16_IMM;
          r.src = (op[3:0] == bcs_pkg::OP_LOAD_INDEX) ? bcs_pkg::SRC_X : bcs_pkg::SRC_D;
        end
        bcs_pkg::OP_STORE_DOUBLE,
        bcs_pkg::OP_STORE_INDEX: begin
          r.cls = dir ? bcs_pkg::CL_ST16 : bcs_pkg::CL_NONE;
          r.src = (op[3:0] == bcs_pkg::OP_STORE_INDEX) ? bcs_pkg::SRC_X : bcs_pkg::SRC_D;
        end
        default: r.cls = bcs_pkg::CL_NONE;
      endcase
    end
    return r;
  endfunction : decode

  // Internal locations answer from the local array, never from the pins
  assign rd = is_int(bus_q.addr) ? ram_q[idx(bus_q.addr)] : i_din;
  assign sv = (src_q == bcs_pkg::SRC_S) ? i_sreg :
              (src_q == bcs_pkg::SRC_X) ? i_xreg : i_dreg;

  always_comb begin
    dec          = decode(rd);
    st_d         = st_q;
    cls_d        = cls_q;
    src_d        = src_q;
    pc_d         = pc_q;
    nxt_d        = nxt_q;
    ea_d         = ea_q;
    opnd_d       = opnd_q;
    vld_d        = 1'b0;
    fin          = 1'b0;
    wr           = 1'b0;
    cap          = 1'b0;
    wdat         = 8'h00;
    bus_d.addr   = nxt_q;
    unique case (st_q)
      bcs_pkg::ST_OPC: begin
        pc_d  = bus_q.addr;
        cls_d = dec.cls;
        src_d = dec.src;
        if (dec.cls == bcs_pkg::CL_NONE) begin
          // Unknown opcodes act as one-byte no-ops
          bus_d.addr = bus_q.addr + bcs_pkg::LEN_UNKNOWN;
          nxt_d      = bus_d.addr;
        end else begin
          bus_d.addr = bus_q.addr + 16'h0001;
          nxt_d      = bus_q.addr + ((dec.cls == bcs_pkg::CL_LD16_IMM ||
                       dec.cls == bcs_pkg::CL_AR16_IMM) ? bcs_pkg::LEN_WIDE_IMM
                       : bcs_pkg::LEN_SHORT);
          st_d       = bcs_pkg::ST_C2;
        end
      end
      bcs_pkg::ST_C2: begin
        ea_d       = rd;
        bus_d.addr = {8'h00, rd};
        st_d       = bcs_pkg::ST_C3;
        case (cls_q)
          bcs_pkg::CL_ACC_IMM: begin
            cap = 1'b1;
            fin = 1'b1;
          end
          bcs_pkg::CL_LD16_IMM, bcs_pkg::CL_AR16_IMM: begin
            cap        = 1'b1;
            bus_d.addr = pc_q + 16'h0002; // [RULE5]
          end
          bcs_pkg::CL_STA: begin
            wr   = 1'b1;
            wdat = i_acc; // [RULE1]
          end
          bcs_pkg::CL_ST16: begin
            wr   = 1'b1;
            wdat = sv[15:8]; // [RULE3] [RULE7]
          end
          bcs_pkg::CL_ACC_DIR, bcs_pkg::CL_LD16_DIR,
          bcs_pkg::CL_AR16_DIR, bcs_pkg::CL_JSR: ; // [RULE9]
          default: fin = 1'b1;
        endcase
      end
      bcs_pkg::ST_C3: begin
        st_d = bcs_pkg::ST_C4;
        case (cls_q)
          bcs_pkg::CL_ACC_DIR, bcs_pkg::CL_LD16_IMM: begin
            cap = 1'b1;
            fin = 1'b1;
          end
          bcs_pkg::CL_AR16_IMM: begin
            cap        = 1'b1;
            bus_d.addr = bcs_pkg::DUMMY_ADDR; // [RULE8]
          end
          bcs_pkg::CL_LD16_DIR, bcs_pkg::CL_AR16_DIR: begin
            cap        = 1'b1;
            bus_d.addr = {8'h00, ea_q} + 16'h0001; // [RULE6]
          end
          bcs_pkg::CL_ST16: begin
            wr         = 1'b1;
            wdat       = sv[7:0];
            bus_d.addr = {8'h00, ea_q} + 16'h0001; // [RULE7]
          end
          bcs_pkg::CL_JSR: begin
            wr         = 1'b1;
            wdat       = nxt_q[7:0];
            bus_d.addr = i_sreg; // [RULE10]
          end
          default: fin = 1'b1;
        endcase
      end
      bcs_pkg::ST_C4: begin
        st_d = bcs_pkg::ST_C5;
        case (cls_q)
          bcs_pkg::CL_LD16_DIR: begin
            cap = 1'b1;
            fin = 1'b1;
          end
          bcs_pkg::CL_AR16_DIR: begin
            cap        = 1'b1;
            bus_d.addr = bcs_pkg::DUMMY_ADDR; // [RULE8]
          end
          bcs_pkg::CL_JSR: begin
            wr         = 1'b1;
            wdat       = nxt_q[15:8];
            bus_d.addr = bus_q.addr + 16'h0001; // [RULE10]
          end
          default: fin = 1'b1;
        endcase
      end
      bcs_pkg::ST_C5: fin = 1'b1;
    endcase
    if (cap) begin
      opnd_d = {opnd_q[7:0], rd};
      vld_d  = fin;
    end
    // Next opcode fetch in the cycle right after the last one
    if (fin) begin
      st_d       = bcs_pkg::ST_OPC;
      bus_d.addr = (cls_q == bcs_pkg::CL_JSR) ? {8'h00, ea_q} : nxt_q; // [RULE11]
    end
    // Registered so the fetch strobe is glitch-free at the pin
    fetch_d = (st_d == bcs_pkg::ST_OPC);
    bus_d.rw = ~wr; // [RULE1]
    if (wr) begin
      bus_d.dout = wdat;
      bus_d.doe  = 1'b1;
    end else if (is_int(bus_d.addr)) begin
      bus_d.dout = i_mode0 ? ram_q[idx(bus_d.addr)] : 8'h00;
      bus_d.doe  = i_mode0; // [RULE4]
    end else begin
      bus_d.dout = 8'h00;
      bus_d.doe  = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_q  <= '{addr: P_START, rw: 1'b1, dout: 8'h00, doe: 1'b0};
      st_q   <= bcs_pkg::ST_OPC;
      cls_q  <= bcs_pkg::CL_NONE;
      src_q  <= bcs_pkg::SRC_D;
      pc_q   <= 16'h0000;
      nxt_q  <= 16'h0000;
      ea_q   <= 8'h00;
      opnd_q <= 16'h0000;
      vld_q  <= 1'b0;
      fetch_q <= 1'b1;
    end else begin
      bus_q  <= bus_d;
      st_q   <= st_d;
      cls_q  <= cls_d;
      src_q  <= src_d;
      pc_q   <= pc_d;
      nxt_q  <= nxt_d;
      ea_q   <= ea_d;
      opnd_q <= opnd_d;
      vld_q  <= vld_d;
      fetch_q <= fetch_d;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge i_clk) begin
    if (!bus_q.rw && is_int(bus_q.addr)) begin
      ram_q[idx(bus_q.addr)] <= bus_q.dout;
    end
  end

  assign o_addr     = bus_q.addr;
  assign o_rw       = bus_q.rw;
  assign o_dout     = bus_q.dout;
  assign o_doe      = bus_q.doe;
  assign o_fetch    = fetch_q;
  assign o_opnd     = opnd_q;
  assign o_opnd_vld = vld_q;

  sta_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE1]
    (st_q == bcs_pkg::ST_C3 && cls_q == bcs_pkg::CL_STA) |->
    !o_rw && o_doe && o_addr == {8'h00, ea_q} && o_dout == $past(i_acc))
    else $error("store accumulator write cycle wrong");
  acc_imm_seq_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE2]
    (st_q == bcs_pkg::ST_OPC && dec.cls == bcs_pkg::CL_ACC_IMM) |=>
    o_rw && o_addr == $past(o_addr) + 16'h0001 ##1
    st_q == bcs_pkg::ST_OPC && o_addr == $past(o_addr, 2) + 16'h0002)
    else $error("immediate accumulator sequence wrong");
  acc_dir_seq_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE2]
    (st_q == bcs_pkg::ST_C2 && cls_q == bcs_pkg::CL_ACC_DIR) |=>
    o_rw && o_addr == {8'h00, $past(rd)} ##1 st_q == bcs_pkg::ST_OPC)
    else $error("direct accumulator sequence wrong");
  wide_order_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE3]
    (st_q == bcs_pkg::ST_C4 && cls_q == bcs_pkg::CL_ST16) |->
    o_addr == $past(o_addr) + 16'h0001 && o_dout == $past(sv[7:0]) &&
    $past(o_dout) == $past(sv[15:8], 2))
    else $error("sixteen-bit byte order wrong");
  int_hidden_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE4]
    (o_rw && is_int(o_addr)) |-> o_doe == $past(i_mode0))
    else $error("internal read visibility wrong");
  ld_imm_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE5]
    (st_q == bcs_pkg::ST_C3 && cls_q == bcs_pkg::CL_LD16_IMM) |->
    o_rw && o_addr == pc_q + 16'h0002 ##1 st_q == bcs_pkg::ST_OPC && o_opnd_vld)
    else $error("immediate wide load sequence wrong");
  ld_dir_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE6]
    (st_q == bcs_pkg::ST_C4 && cls_q == bcs_pkg::CL_LD16_DIR) |->
    o_rw && o_addr == {8'h00, ea_q} + 16'h0001 ##1 st_q == bcs_pkg::ST_OPC)
    else $error("direct wide load sequence wrong");
  st_dir_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE7]
    (st_q == bcs_pkg::ST_C3 && cls_q == bcs_pkg::CL_ST16) |->
    !o_rw ##1 !o_rw ##1 st_q == bcs_pkg::ST_OPC && o_rw)
    else $error("direct wide store sequence wrong");
  dummy_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE8]
    ((st_q == bcs_pkg::ST_C4 && cls_q == bcs_pkg::CL_AR16_IMM) ||
     (st_q == bcs_pkg::ST_C5 && cls_q == bcs_pkg::CL_AR16_DIR)) |->
    o_rw && o_addr == bcs_pkg::DUMMY_ADDR ##1 st_q == bcs_pkg::ST_OPC)
    else $error("dummy restart read wrong");
  call_fetch_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE9]
    (st_q == bcs_pkg::ST_C2 && cls_q == bcs_pkg::CL_JSR) |->
    o_rw && o_addr == pc_q + 16'h0001 ##1 o_rw && o_addr == {8'h00, $past(rd)})
    else $error("call early cycles wrong");
  call_push_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE10]
    (st_q == bcs_pkg::ST_C4 && cls_q == bcs_pkg::CL_JSR) |->
    !o_rw && o_addr == $past(i_sreg) && o_dout == nxt_q[7:0] ##1
    !o_rw && o_addr == $past(o_addr) + 16'h0001 && o_dout == nxt_q[15:8])
    else $error("call return push wrong");
  next_fetch_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE11]
    (st_q == bcs_pkg::ST_OPC && $past(st_q) != bcs_pkg::ST_OPC &&
     $past(cls_q) != bcs_pkg::CL_JSR) |-> o_rw && o_addr == $past(nxt_q))
    else $error("next opcode fetch wrong");

endmodule : bcs_seq

// File: bcs_mem_model.sv
// Purpose: Memory on the processor bus
// Assumes: Reads answer within the cycle; writes land at cycle end
// Notes:   Internal range gets a toggling pattern, so a leak shows
`timescale 1ns/10ps
module bcs_mem_model #(
  parameter logic [15:0] P_BASE  = 16'h0080,
  parameter int          P_DEPTH = 128
) (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rw,
  input  wire logic [7:0]  i_dout,
  output logic      [7:0]  o_din
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk_q = 8'hA5;
  logic       intl;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
  end
  assign intl = (i_addr >= P_BASE) && (i_addr < P_BASE + 16'(P_DEPTH));
  always @(posedge i_clk) begin
    junk_q <= ~junk_q;
    if (!i_rw) begin
      mem[i_addr] <= i_dout;
    end
  end
  // Stale bytes never survive a write or an internal cycle
  assign o_din = (i_rw && !intl) ? mem[i_addr] : junk_q;
endmodule : bcs_mem_model

// File: testbench.sv
// Purpose: Random instruction stream checked cycle by cycle at the bus
// Assumes: Code stays outside internal RAM; call targets kept below 0040
// Notes:   Expected cycles come from bench functions, not from the design
`timescale 1ns/10ps
module testbench;
  localparam logic [15:0] START = 16'h0400;
  localparam int          LIMIT = 20000;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_mode0 = 1'b0;
  logic [7:0]  i_acc = 8'h00;
  logic [15:0] i_dreg = 16'h0000;
  logic [15:0] i_xreg = 16'h0000;
  logic [15:0] i_sreg = 16'h0000;
  wire  [7:0]  i_din;
  logic [15:0] o_addr, o_opnd;
  logic [7:0]  o_dout;
  logic        o_rw, o_doe, o_fetch, o_opnd_vld;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'd60621;
  logic [15:0] pc, nx_d, nx_x, nx_s;
  logic [7:0]  nx_acc;
  logic        nx_m0 = 1'b0;
  logic [7:0]  mirror [0:127];
  bit          known [0:127];
  logic [7:0]  c_op [0:6] = '{8'h97, 8'h96, 8'hDD, 8'hDC, 8'hC3, 8'h93, 8'h9D};
  logic [7:0]  c_b1 [0:6] = '{8'h80, 8'h80, 8'h7F, 8'h7F, 8'h00, 8'hFF, 8'h10};

  bcs_seq #(.P_START(START)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_din(i_din),
    .i_mode0(i_mode0), .i_acc(i_acc), .i_dreg(i_dreg), .i_xreg(i_xreg),
    .i_sreg(i_sreg), .o_addr(o_addr), .o_rw(o_rw), .o_dout(o_dout), .o_doe(o_doe),
    .o_fetch(o_fetch), .o_opnd(o_opnd), .o_opnd_vld(o_opnd_vld));
  bcs_mem_model mem_i (.i_clk(i_clk), .i_addr(o_addr), .i_rw(o_rw),
    .i_dout(o_dout), .o_din(i_din));

  always #5 i_clk = ~i_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Bus-cycle class: 0 no-op, 1/2 acc, 3 store acc, 4/5 wide load,
  // 6 wide store, 7/8 wide arithmetic, 9 call
  function automatic int kind(input logic [7:0] op);
    logic d;
    d = op[4];
    if (op[7:4] == 4'h8 || op[7:4] == 4'h9) begin
      case (op[3:0])
        4'h3, 4'hC: return d ? 8 : 7;
        4'h7:       return d ? 3 : 0;
        4'hD:       return d ? 9 : 0;
        4'hE:       return d ? 5 : 4;
        4'hF:       return d ? 6 : 0;
        default:    return d ? 2 : 1;
      endcase
    end
    if (op[7:4] == 4'hC || op[7:4] == 4'hD) begin
      case (op[3:0])
        4'h3:       return d ? 8 : 7;
        4'hC, 4'hE: return d ? 5 : 4;
        4'hD, 4'hF: return d ? 6 : 0;
        default:    return 0;
      endcase
    end
    return 0;
  endfunction : kind

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk

  // Entered at the falling edge of a cycle, leaves at the next one
  task automatic step(input logic [15:0] a, input logic wr, input logic [7:0] d,
                      input logic f);
    logic       in;
    logic [7:0] ed;
    in = (a >= 16'h0080) && (a < 16'h0100);
    ed = wr ? d : ((in && i_mode0) ? mirror[a[6:0]] : 8'h00);
    chk("addr", a, o_addr);
    chk("rw", {15'h0, !wr}, {15'h0, o_rw});
    chk("fetch", {15'h0, f}, {15'h0, o_fetch});
    chk("doe", {15'h0, wr || (in && i_mode0)}, {15'h0, o_doe});
    if (wr || !in || !i_mode0 || known[a[6:0]]) chk("dout", {8'h00, ed}, {8'h00, o_dout});
    if (wr && in) begin
      mirror[a[6:0]] = d;
      known[a[6:0]] = 1'b1;
    end
    @(posedge i_clk);
    i_acc <= nx_acc;
    i_dreg <= nx_d;
    i_xreg <= nx_x;
    i_sreg <= nx_s;
    i_mode0 <= nx_m0;
    @(negedge i_clk);
  endtask : step

  task automatic run_instr(input bit fx, input logic [7:0] fop, input logic [7:0] fb1);
    logic [31:0] r, r2, r3;
    logic [7:0]  op, b1, b2;
    logic [15:0] dd, ret, src;
    r = rnd();
    r2 = rnd();
    r3 = rnd();
    op = r[2:0] == 3'd0 ? r[15:8] : {r[4] ? (r[3] ? 4'hD : 4'hC) : (r[3] ? 4'h9 : 4'h8), r[11:8]};
    b1 = r[23:16];
    b2 = r[31:24];
    if (fx) begin
      op = fop;
      b1 = fb1;
    end
    // Low code must call back before reaching internal RAM
    if (pc >= 16'h0060 && pc < 16'h0100) op = 8'h9D;
    if (op == 8'h9D) b1 = {2'b00, b1[5:0]};
    mem_i.mem[pc] = op;
    mem_i.mem[pc + 16'd1] = b1;
    mem_i.mem[pc + 16'd2] = b2;
    nx_acc = r2[31:24];
    nx_m0 = r2[1];
    nx_s = r2[0] ? {9'h001, r2[7:2], 1'b0} : {4'h2, r2[19:8]};
    nx_d = r3[15:0];
    nx_x = r3[31:16];
    dd = {8'h00, b1};
    ret = pc + 16'd2;
    src = op[7:4] == 4'h9 ? nx_s : (op[3:0] == 4'hD ? nx_d : nx_x);
    step(pc, 1'b0, 8'h00, 1'b1);
    if (kind(op) != 0) step(pc + 16'd1, 1'b0, 8'h00, 1'b0);
    case (kind(op))
      0: pc = pc + 16'd1;
      1: pc = ret;
      2, 3, 5, 6, 8, 9: begin
        step(dd, kind(op) == 3 || kind(op) == 6, kind(op) == 3 ? nx_acc : src[15:8], 1'b0);
        if (kind(op) >= 5 && kind(op) != 9) step(dd + 16'd1, kind(op) == 6, src[7:0], 1'b0);
        if (kind(op) == 8) step(16'hFFFF, 1'b0, 8'h00, 1'b0);
        if (kind(op) == 9) step(nx_s, 1'b1, ret[7:0], 1'b0);
        if (kind(op) == 9) step(nx_s + 16'd1, 1'b1, ret[15:8], 1'b0);
        pc = kind(op) == 9 ? dd : ret;
      end
      default: begin
        step(pc + 16'd2, 1'b0, 8'h00, 1'b0);
        if (kind(op) == 7) step(16'hFFFF, 1'b0, 8'h00, 1'b0);
        pc = pc + 16'd3;
      end
    endcase
    if (kind(op) == 4) begin
      chk("opnd_vld", 16'h0001, {15'h0, o_opnd_vld});
      chk("opnd", {b1, b2}, o_opnd);
    end
  endtask : run_instr

  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge i_clk);
    chk("rst_addr", START, o_addr);
    chk("rst_doe", 16'h0000, {15'h0, o_doe});
    i_nrst <= 1'b1;
    pc = START;
    @(negedge i_clk);
    for (int i = 0; i < 7; i++) begin
      run_instr(1'b1, c_op[i], c_b1[i]);
    end
    repeat (3000) run_instr(1'b0, 8'h00, 8'h00);
    end_of_test();
  end
endmodule : testbench
